// ==== quasi_port_pkg.sv ====
/*
 Constants for the quasi-bidirectional port block: register map,
 field positions, reset values, strobe timing and operation codes.
 Assumes a 32-bit AHB-Lite register bus decoded on byte address.
*/
package quasi_port_pkg;
	localparam int NUM_PORTS = 5;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] LATCH_RESET = 8'hFF;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] BIT_ONE = 8'h01;
	localparam logic [7:0] LATCH_BASE = 8'h00;
	localparam logic [7:0] PIN_BASE = 8'h20;
	localparam logic [7:0] CTRL_OFS = 8'h40;
	localparam logic [7:0] RMW_OFS = 8'h44;
	localparam logic [7:0] STAT_OFS = 8'h48;
	localparam int ADDR_DATA_PORT = 0;
	localparam int ANALOG_PORT = 1;
	localparam int HIGH_ADDR_PORT = 2;
	localparam int CTRL_X2_BIT = 0;
	localparam int CTRL_ALE_OFF_BIT = 1;
	localparam int CTRL_ANALOG_LSB = 8;
	localparam int RMW_OP_LSB = 0;
	localparam int RMW_PORT_LSB = 4;
	localparam int RMW_BIT_LSB = 8;
	localparam int RMW_OPND_LSB = 16;
	localparam int RMW_CARRY_BIT = 24;
	localparam int RES_JUMP_BIT = 8;
	localparam int STAT_EA_BIT = 0;
	localparam int STAT_EXT_FETCH_BIT = 1;
	localparam logic [2:0] ALE_PERIOD_STD = 3'h6;
	localparam logic [2:0] ALE_PERIOD_X2 = 3'h3;
	localparam logic [2:0] PROG_STORE_STROBE_PHASE_STD = 3'h3;
	localparam logic [2:0] PROG_STORE_STROBE_PHASE_X2 = 3'h1;
	localparam logic [2:0] PHASE_ONE = 3'h1;
	localparam logic [2:0] PHASE_ZERO = 3'h0;
	typedef enum logic [3:0] {
		OP_AND = 4'h0, OP_OR = 4'h1, OP_XOR = 4'h2, OP_JBC = 4'h3,
		OP_CPL_BIT = 4'h4, OP_INC = 4'h5, OP_DEC = 4'h6, OP_DJNZ = 4'h7,
		OP_MOV_C = 4'h8, OP_CLR_BIT = 4'h9, OP_SET_BIT = 4'hA, OP_CPL = 4'hB
	} rmw_op_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00, BUS_WRITE = 2'b01, BUS_READ_WAIT = 2'b10, BUS_READ_DONE = 2'b11
	} bus_state_t;
endpackage

// ==== quasi_port.sv ====
/*
 Port latches, pin drivers and bus strobes for five byte-wide ports,
 with an AHB-Lite slave for the latch, pin, control and RMW registers.
 Assumes hclk is the oscillator clock, all pin inputs are synchronous
 to it, and the core supplies bus-cycle and external-data flags.
*/
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
// Behaviour
// - Port write loads latch from bus
// - Latch read returns latch, not pin
// - Pin read returns pin levels
// - Each line input or output independently
// - Latch one releases low driver
// - Alternate output drives when latch set
// - External low reads back as zero
// - Analog port pull-up switchable off
// - Address/data port open-drain outside bus
// - High-address port strong pull during bus
// - Bus cycle drives address/data, not latch
// - Bus ports unusable as GPIO meanwhile
// - RMW operations read latch, not pin
// - Bit operations rewrite whole byte
// - Address strobe every six, three; skip data
// - Software may disable strobe when internal
// - Program strobe twice per cycle, skip data
// - Program strobe idle on internal fetch
// - Access select low fetches all externally
// - Reset sets every latch bit
`timescale 1ns/1ps
`default_nettype none
module quasi_port #(
	parameter int NPORT = quasi_port_pkg::NUM_PORTS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [NPORT*8-1:0] pin_in,
	output logic [NPORT*8-1:0] pin_out,
	output logic [NPORT*8-1:0] pin_oe,
	output logic [NPORT*8-1:0] pin_pullup,
	input wire logic [NPORT*8-1:0] alt_func_out,
	input wire logic ext_bus_cycle,
	input wire logic xdata_access,
	input wire logic [7:0] addr_data_out,
	input wire logic [7:0] high_addr_out,
	input wire logic ext_access_sel,
	output logic addr_latch_strobe,
	output logic prog_store_strobe_n
);
	logic [7:0] port_latch_reg [NPORT];
	logic [NPORT*8-1:0] sync1_reg;
	logic [NPORT*8-1:0] sync2_reg;
	quasi_port_pkg::bus_state_t state_reg;
	quasi_port_pkg::bus_state_t state_next;
	logic [7:0] addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] ctrl_reg;
	logic [8:0] rmw_result_reg;
	logic [2:0] phase_reg;
	logic [2:0] period;
	logic [2:0] prog_store_strobe_phase;
	logic double_speed_mode;
	logic ale_off;
	logic [7:0] analog_sel;
	logic take;
	logic commit;
	logic [3:0] lat_hit;
	logic [3:0] pin_hit;
	logic [2:0] rmw_port;
	logic [8:0] rmw_calc_val;

	// Valid bit plus port index for a register bank
	function automatic logic [3:0] port_dec(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		port_dec = {(a >= base) && (d[1:0] == 2'b00) && (d[7:2] < NPORT), d[4:2]};
	endfunction

	function automatic logic [8:0] rmw_calc(input logic [3:0] op, input logic [7:0] l,
		input logic [2:0] b, input logic [7:0] v, input logic c);
		logic [7:0] m;
		logic [7:0] d;
		m = quasi_port_pkg::BIT_ONE << b;
		d = l - quasi_port_pkg::BIT_ONE;
		case (op)
		quasi_port_pkg::OP_AND: rmw_calc = {1'b0, l & v};
		quasi_port_pkg::OP_OR: rmw_calc = {1'b0, l | v};
		quasi_port_pkg::OP_XOR: rmw_calc = {1'b0, l ^ v};
		quasi_port_pkg::OP_JBC: rmw_calc = {l[b], l & ~m};
		quasi_port_pkg::OP_CPL_BIT: rmw_calc = {1'b0, l ^ m};
		quasi_port_pkg::OP_INC: rmw_calc = {1'b0, l + quasi_port_pkg::BIT_ONE};
		quasi_port_pkg::OP_DEC: rmw_calc = {1'b0, d};
		quasi_port_pkg::OP_DJNZ: rmw_calc = {d != 8'h00, d};
		quasi_port_pkg::OP_MOV_C: rmw_calc = {1'b0, c ? (l | m) : (l & ~m)};
		quasi_port_pkg::OP_CLR_BIT: rmw_calc = {1'b0, l & ~m};
		quasi_port_pkg::OP_SET_BIT: rmw_calc = {1'b0, l | m};
		quasi_port_pkg::OP_CPL: rmw_calc = {1'b0, ~l};
		default: rmw_calc = {1'b0, l};
		endcase
	endfunction

	assign hresp = 1'b0;
	assign hreadyout = (state_reg != quasi_port_pkg::BUS_READ_WAIT);
	assign hrdata = hrdata_reg;
	assign take = hsel && htrans[1] && hready;
	assign commit = (state_reg == quasi_port_pkg::BUS_WRITE);
	assign lat_hit = port_dec(addr_reg, quasi_port_pkg::LATCH_BASE);
	assign pin_hit = port_dec(addr_reg, quasi_port_pkg::PIN_BASE);
	assign rmw_port = hwdata[quasi_port_pkg::RMW_PORT_LSB +: 3];
	assign double_speed_mode = ctrl_reg[quasi_port_pkg::CTRL_X2_BIT];
	assign ale_off = ctrl_reg[quasi_port_pkg::CTRL_ALE_OFF_BIT];
	assign analog_sel = ctrl_reg[quasi_port_pkg::CTRL_ANALOG_LSB +: 8];

	always_comb begin
		rmw_calc_val = rmw_calc(hwdata[quasi_port_pkg::RMW_OP_LSB +: 4],
			port_latch_reg[rmw_port < NPORT ? rmw_port : 3'h0],
			hwdata[quasi_port_pkg::RMW_BIT_LSB +: 3],
			hwdata[quasi_port_pkg::RMW_OPND_LSB +: 8],
			hwdata[quasi_port_pkg::RMW_CARRY_BIT]);
	end

	// Reads take one wait state so a write just before is already visible
	always_comb begin
		state_next = quasi_port_pkg::BUS_IDLE;
		if (state_reg == quasi_port_pkg::BUS_READ_WAIT) begin
			state_next = quasi_port_pkg::BUS_READ_DONE;
		end else if (take) begin
			state_next = hwrite ? quasi_port_pkg::BUS_WRITE : quasi_port_pkg::BUS_READ_WAIT;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= quasi_port_pkg::BUS_IDLE;
			addr_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (take && (state_reg != quasi_port_pkg::BUS_READ_WAIT)) begin
				addr_reg <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (state_reg == quasi_port_pkg::BUS_READ_WAIT) begin
			hrdata_reg <= 32'h0000_0000;
			if (lat_hit[3]) begin
				hrdata_reg[7:0] <= port_latch_reg[lat_hit[2:0]];
			end else if (pin_hit[3]) begin
				hrdata_reg[7:0] <= sync2_reg[pin_hit[2:0]*8 +: 8];
			end else if (addr_reg == quasi_port_pkg::CTRL_OFS) begin
				hrdata_reg <= ctrl_reg;
			end else if (addr_reg == quasi_port_pkg::RMW_OFS) begin
				hrdata_reg[8:0] <= rmw_result_reg;
			end else if (addr_reg == quasi_port_pkg::STAT_OFS) begin
				hrdata_reg[quasi_port_pkg::STAT_EA_BIT] <= ext_access_sel;
				hrdata_reg[quasi_port_pkg::STAT_EXT_FETCH_BIT] <= !ext_access_sel;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= 32'h0000_0000;
		end else if (commit && addr_reg == quasi_port_pkg::CTRL_OFS) begin
			ctrl_reg <= hwdata & 32'h0000_FF03;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rmw_result_reg <= 9'h000;
		end else if (commit && addr_reg == quasi_port_pkg::RMW_OFS && rmw_port < NPORT) begin
			rmw_result_reg <= rmw_calc_val;
		end
	end

	generate
		for (genvar p = 0; p < NPORT; p++) begin : g_port
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					port_latch_reg[p] <= quasi_port_pkg::LATCH_RESET;
				end else if (commit && lat_hit[3] && lat_hit[2:0] == p) begin
					port_latch_reg[p] <= hwdata[7:0];
				end else if (commit && addr_reg == quasi_port_pkg::RMW_OFS && rmw_port == p) begin
					port_latch_reg[p] <= rmw_calc_val[7:0];
				end
			end
			// every bit driven from its own latch bit outside bus cycles
			if (p == quasi_port_pkg::ADDR_DATA_PORT) begin : g_ad
				assign pin_out[p*8 +: 8] = ext_bus_cycle ? addr_data_out : 8'h00;
				assign pin_oe[p*8 +: 8] = ext_bus_cycle ? quasi_port_pkg::ALL_ONES : ~port_latch_reg[p];
				assign pin_pullup[p*8 +: 8] = 8'h00;
			end else if (p == quasi_port_pkg::HIGH_ADDR_PORT) begin : g_ha
				assign pin_out[p*8 +: 8] = ext_bus_cycle ? high_addr_out : 8'h00;
				assign pin_oe[p*8 +: 8] = ext_bus_cycle ? quasi_port_pkg::ALL_ONES : ~port_latch_reg[p];
				assign pin_pullup[p*8 +: 8] = quasi_port_pkg::ALL_ONES;
			end else begin : g_qb
				assign pin_oe[p*8 +: 8] = ~(port_latch_reg[p] & alt_func_out[p*8 +: 8]);
				// only low side driven; weak pull lets outside pull low
				assign pin_out[p*8 +: 8] = 8'h00;
				if (p == quasi_port_pkg::ANALOG_PORT) begin : g_an
					assign pin_pullup[p*8 +: 8] = ~analog_sel;
				end else begin : g_dg
					assign pin_pullup[p*8 +: 8] = quasi_port_pkg::ALL_ONES;
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	assign period = double_speed_mode ? quasi_port_pkg::ALE_PERIOD_X2 : quasi_port_pkg::ALE_PERIOD_STD;
	assign prog_store_strobe_phase = double_speed_mode ? quasi_port_pkg::PROG_STORE_STROBE_PHASE_X2 : quasi_port_pkg::PROG_STORE_STROBE_PHASE_STD;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= quasi_port_pkg::PHASE_ZERO;
		end else if (phase_reg >= period - quasi_port_pkg::PHASE_ONE) begin
			phase_reg <= quasi_port_pkg::PHASE_ZERO;
		end else begin
			phase_reg <= phase_reg + quasi_port_pkg::PHASE_ONE;
		end
	end

	// one pulse per period, none on data access; off only when internal
	assign addr_latch_strobe = (phase_reg == quasi_port_pkg::PHASE_ZERO) && !xdata_access
		&& !(ale_off && ext_access_sel);
	// one per half machine cycle; external fetch only when select low
	assign prog_store_strobe_n = !((phase_reg == prog_store_strobe_phase) && !ext_access_sel && !xdata_access);

	// A switch to double speed shortens the period, so the gap is checked in standard speed only
	sequence std_gap;
		(!addr_latch_strobe || double_speed_mode)[*5];
	endsequence

	a_latch_write_load: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && lat_hit[3] && lat_hit[2:0] == 3'h3 |=> port_latch_reg[3] == $past(hwdata[7:0]))
		else $error("latch write not loaded");
	a_latch_read_path: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == quasi_port_pkg::BUS_READ_WAIT && lat_hit[3] && lat_hit[2:0] == 3'h1
		|=> hrdata[7:0] == $past(port_latch_reg[1]) && hreadyout)
		else $error("latch read wrong");
	a_pin_read_sync: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == quasi_port_pkg::BUS_READ_WAIT && pin_hit[3] && pin_hit[2:0] == 3'h1
		|=> hrdata[7:0] == $past(pin_in[15:8], 3))
		else $error("pin read not two-stage");
	a_quasi_alt_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		pin_oe[31:24] == ~(port_latch_reg[3] & alt_func_out[31:24]) && pin_out[31:24] == 8'h00)
		else $error("alternate output drive wrong");
	a_bus_drive_ad: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_bus_cycle |-> pin_out[7:0] == addr_data_out && pin_oe[7:0] == 8'hFF
		&& pin_out[23:16] == high_addr_out && pin_oe[23:16] == 8'hFF)
		else $error("bus port not driving bus line");
	a_open_drain_ad: assert property (@(posedge hclk) disable iff (!hresetn)
		!ext_bus_cycle |-> (pin_out[7:0] | pin_pullup[7:0]) == 8'h00 && pin_oe[7:0] == ~port_latch_reg[0])
		else $error("address/data port not open-drain");
	a_analog_pull_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_pullup[15:8] & analog_sel) == 8'h00)
		else $error("analog pull-up left on");
	a_ale_period_std: assert property (@(posedge hclk) disable iff (!hresetn)
		addr_latch_strobe && !double_speed_mode |=> std_gap)
		else $error("address strobe gap wrong");
	a_xdata_skip: assert property (@(posedge hclk) disable iff (!hresetn)
		xdata_access |-> !addr_latch_strobe && prog_store_strobe_n)
		else $error("strobe during data access");
	a_prog_store_strobe_internal: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_access_sel |-> prog_store_strobe_n)
		else $error("program strobe on internal fetch");
	a_prog_store_strobe_external: assert property (@(posedge hclk) disable iff (!hresetn)
		!ext_access_sel && !xdata_access && !double_speed_mode |-> ##[0:5] (!prog_store_strobe_n || xdata_access))
		else $error("no external fetch strobe");
	a_rmw_bit_only: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && addr_reg == quasi_port_pkg::RMW_OFS && rmw_port == 3'h3
		&& hwdata[3:0] == quasi_port_pkg::OP_SET_BIT
		|=> port_latch_reg[3] == ($past(port_latch_reg[3]) | (8'h01 << $past(hwdata[10:8]))))
		else $error("bit set changed other bits");
endmodule
`default_nettype wire

// ==== quasi_pin_model.sv ====
/*
 Model of the board around the port pins: external drivers, weak pull-ups
 and floating lines. Assumes one pin per bit, port p at bits 8p+7:8p.
*/
`timescale 1ns/1ps
`default_nettype none
module quasi_pin_model #(
	parameter int W = 40
) (
	input wire logic hclk,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	input wire logic [W-1:0] pin_pullup,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] pin_level
);
	logic [W-1:0] float_reg = '0;
	// Undriven lines without pull-up toggle so a stale value is never mistaken for a read
	always_ff @(posedge hclk) begin
		float_reg <= ~float_reg;
	end
	// device driver first, then board source, then pull-up
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (pin_oe[i]) begin
				pin_level[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_level[i] = ext_val[i];
			end else begin
				pin_level[i] = pin_pullup[i] ? 1'b1 : float_reg[i];
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb.sv ====
/*
 Self-checking bench for the port block: AHB-Lite master tasks, pin board
 model, strobe counting. Assumes one slave, hready fed from hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic hclk, hresetn, hsel, hwrite, ext_bus_cycle, xdata_access, ext_access_sel;
	logic hreadyout, hresp, addr_latch_strobe, prog_store_strobe_n;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [7:0] addr_data_out, high_addr_out;
	logic [39:0] pin_in, pin_out, pin_oe, pin_pullup, alt_func_out, ext_en, ext_val;
	logic [31:0] rmw_cmd [12];
	logic [7:0] rmw_exp [12];
	logic [11:0] rmw_jmp;
	int err_total, samples_checked, cyc, n_ale, n_ps;
	quasi_port u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .alt_func_out(alt_func_out), .ext_bus_cycle(ext_bus_cycle),
		.xdata_access(xdata_access), .addr_data_out(addr_data_out), .high_addr_out(high_addr_out),
		.ext_access_sel(ext_access_sel), .addr_latch_strobe(addr_latch_strobe),
		.prog_store_strobe_n(prog_store_strobe_n));
	quasi_pin_model u_pins (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Ceiling well above the roughly five hundred cycles the sequence needs
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_sim();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Ready is looked at mid-cycle, so the edge that ends a phase never races it
	task automatic wait_ready();
		logic r;
		do begin
			@(negedge hclk);
			r = hreadyout;
			rd = hrdata;
			@(posedge hclk);
		end while (r !== 1'b1);
	endtask
	task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
	endtask
	task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		wait_ready();
		htrans <= 2'h0;
		wait_ready();
		d = rd;
	endtask
	task automatic count_strobes(input int n);
		n_ale = 0;
		n_ps = 0;
		repeat (12) @(posedge hclk);
		repeat (n) begin
			@(negedge hclk);
			n_ale = n_ale + (addr_latch_strobe === 1'b1 ? 1 : 0);
			n_ps = n_ps + (prog_store_strobe_n === 1'b0 ? 1 : 0);
		end
		@(posedge hclk);
	endtask
	initial begin
		logic [31:0] v;
		cyc = 0;
		err_total = 0;
		samples_checked = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = '0;
		alt_func_out = '1;
		ext_bus_cycle = 1'b0;
		xdata_access = 1'b0;
		addr_data_out = 8'h3C;
		high_addr_out = 8'hC5;
		ext_access_sel = 1'b1;
		ext_en = '0;
		ext_val = '0;
		rmw_cmd = '{32'h000F0030, 32'h000F0031, 32'h00FF0032, 32'h00000133, 32'h00000034, 32'h00000035,
			32'h00000036, 32'h00000037, 32'h01000738, 32'h00000339, 32'h0000003A, 32'h0000003B};
		rmw_exp = '{8'h0A, 8'h5F, 8'hA5, 8'h58, 8'h5B, 8'h5B, 8'h59, 8'h59, 8'hDA, 8'h52, 8'h5B, 8'hA5};
		rmw_jmp = 12'h088;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int p = 0; p < 5; p++) begin
			ahb_read(8'(4 * p), v);
			chk("latch after reset", 32'hFF, v);
		end
		chk("oe after reset low ports", 32'h0, pin_oe[31:0]);
		chk("oe after reset port4", 32'h0, 32'(pin_oe[39:32]));
		ahb_write(8'h0C, 32'h5A);
		ahb_read(8'h0C, v);
		chk("port3 latch", 32'h5A, v);
		chk("port3 oe", 32'hA5, 32'(pin_oe[31:24]));
		ext_en[15:8] <= 8'hFF;
		ext_val[15:8] <= 8'h96;
		repeat (4) @(posedge hclk);
		ahb_read(8'h24, v);
		chk("port1 pin read", 32'h96, v);
		ahb_read(8'h04, v);
		chk("port1 latch with pins low", 32'hFF, v);
		ext_en[31:24] <= 8'hFF;
		ext_val[31:24] <= 8'h00;
		for (int i = 0; i < 12; i++) begin
			ahb_write(8'h0C, 32'h5A);
			ahb_write(8'h44, rmw_cmd[i]);
			ahb_read(8'h0C, v);
			chk("rmw latch", {24'h0, rmw_exp[i]}, v);
			ahb_read(8'h44, v);
			chk("rmw result", {23'h0, rmw_jmp[i], rmw_exp[i]}, v);
		end
		ext_en <= '0;
		alt_func_out[8] <= 1'b0;
		ahb_write(8'h40, 32'h0100);
		// The write lands at the edge the task returns on, so look mid-cycle
		@(negedge hclk);
		chk("alternate output drives", 32'h1, 32'(pin_oe[8]));
		chk("analog pull-up off", 32'h0, 32'(pin_pullup[8]));
		chk("other pull-up on", 32'h1, 32'(pin_pullup[9]));
		@(posedge hclk);
		ahb_write(8'h00, 32'h0F);
		@(negedge hclk);
		chk("port0 open drain oe", 32'hF0, 32'(pin_oe[7:0]));
		chk("port0 no pull-up", 32'h0, 32'(pin_pullup[7:0]));
		@(posedge hclk);
		ext_bus_cycle <= 1'b1;
		@(posedge hclk);
		@(negedge hclk);
		chk("bus cycle port0", 32'hFF3C, 32'({pin_oe[7:0], pin_out[7:0]}));
		chk("bus cycle port2", 32'hFFC5, 32'({pin_oe[23:16], pin_out[23:16]}));
		@(posedge hclk);
		ext_bus_cycle <= 1'b0;
		ext_access_sel <= 1'b0;
		ahb_write(8'h40, 32'h0);
		ahb_read(8'h48, v);
		chk("status external fetch", 32'h2, v);
		count_strobes(60);
		chk("ale per 60 clocks", 32'd10, 32'(n_ale));
		chk("prog_store_strobe per 60 clocks", 32'd10, 32'(n_ps));
		ahb_write(8'h40, 32'h1);
		count_strobes(60);
		chk("ale double speed", 32'd20, 32'(n_ale));
		chk("prog_store_strobe double speed", 32'd20, 32'(n_ps));
		ahb_write(8'h40, 32'h0);
		xdata_access <= 1'b1;
		count_strobes(60);
		chk("ale in data access", 32'd0, 32'(n_ale));
		chk("prog_store_strobe in data access", 32'd0, 32'(n_ps));
		xdata_access <= 1'b0;
		ext_access_sel <= 1'b1;
		ahb_write(8'h40, 32'h2);
		ahb_read(8'h48, v);
		chk("status internal fetch", 32'h1, v);
		count_strobes(60);
		chk("ale disabled", 32'd0, 32'(n_ale));
		chk("prog_store_strobe internal", 32'd0, 32'(n_ps));
		ahb_read(8'h80, v);
		chk("unmapped read", 32'h0, v);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb_read(8'h0C, v);
		chk("latch after second reset", 32'hFF, v);
		end_sim();
	end
endmodule
`default_nettype wire
